// file: hw/spx_exchange.sv
// slot exchange between the scale and the polled fieldbus image
// assumes image words, scale values and ad_tick come from logic on ref_clk
`timescale 1ns/1ps
`include "spx_map.svh"
module spx_exchange
  import spx_pkg::*;
#(
  parameter int ROT_MAX = `SPX_ROT_MAX,
  parameter int DIO_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] plc_out0,
  input wire logic [15:0] plc_out1,
  input wire logic [15:0] plc_out2,
  input wire logic [15:0] plc_out3,
  output logic [15:0] plc_in0,
  output logic [15:0] plc_in1,
  output logic [15:0] plc_in2,
  output logic [15:0] plc_in3,
  input wire logic ad_tick,
  output logic [2:0] slot1_sel,
  input wire logic [15:0] slot1_weight,
  output logic [2:0] slot2_sel,
  input wire logic [15:0] slot2_weight,
  output logic [15:0] slot1_wdata,
  output logic [15:0] slot2_wdata,
  input wire logic [15:0] scale_status,
  output spx_field_type float_sel,
  input wire logic [31:0] float_value,
  output logic load_stb,
  output spx_field_type load_field,
  output logic [31:0] load_value,
  input wire logic [DIO_W-1:0] din_pin,
  output logic [DIO_W-1:0] dout
);
  // ------------------------------------------------------------
  // configuration and register bus
  // ------------------------------------------------------------
  logic [1:0] fmt_q, fmt_d;
  logic two_q, two_d;
  logic [31:0] rdata_q, rdata_d;
  logic bus_app, bus_clr;
  logic flt, two_eff;
  logic [1:0] ack_q, ack_d;
  spx_mode_type mode_q, mode_d;
  spx_field_type cur_sel, rot_cur;
  logic [3:0] rot_cnt, rot_ptr;
  logic [15:0] stat_q, stat_d;

  assign flt = (fmt_q == `SPX_FMT_FLT);
  // float format never offers a second slot
  assign two_eff = two_q && !flt; // RULE1

  always_comb
  begin
    fmt_d = fmt_q;
    two_d = two_q;
    bus_app = 1'b0;
    bus_clr = 1'b0;
    rdata_d = 32'h0000_0000;
    if (reg_wr)
    begin
      case (reg_addr)
        `SPX_OFS_CTRL:
        begin
          fmt_d = reg_wdata[1:0];
          two_d = reg_wdata[`SPX_CTRL_TWO_BIT];
        end
        `SPX_OFS_ROT:
        begin
          bus_clr = reg_wdata[`SPX_ROT_CLR_BIT];
          bus_app = !reg_wdata[`SPX_ROT_CLR_BIT];
        end
        default:
        begin
          fmt_d = fmt_q;
        end
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        `SPX_OFS_CTRL: rdata_d = {29'h0, two_q, fmt_q};
        `SPX_OFS_STATUS: rdata_d = {11'h0, cur_sel, stat_q[3:0], rot_ptr, rot_cnt,
                                    mode_q, ack_q};
        `SPX_OFS_ROT: rdata_d = {27'h0, rot_cur};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fmt_q <= `SPX_RST_FMT;
      two_q <= `SPX_RST_TWO;
      rdata_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      fmt_q <= fmt_d;
      two_q <= two_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // ------------------------------------------------------------
  // discrete inputs and integer image
  // ------------------------------------------------------------
  logic [DIO_W-1:0] din_s1_q, din_s2_q, dout_q, dout_d;
  logic [15:0] w0_q, w0_d, w2_q, w2_d;
  logic [2:0] sel1_q, sel1_d, sel2_q, sel2_d;
  logic [15:0] wd1_q, wd1_d, wd2_q, wd2_d;

  always_comb
  begin
    w0_d = w0_q;
    w2_d = w2_q;
    stat_d = stat_q;
    dout_d = dout_q;
    sel1_d = sel1_q;
    sel2_d = sel2_q;
    wd1_d = wd1_q;
    wd2_d = wd2_q;
    if (ad_tick)
    begin
      // io follows the update tick, so the plc sees up to one tick of lag
      stat_d = {scale_status[15:DIO_W], din_s2_q}; // RULE23
      if (!flt)
        dout_d = plc_out1[8 +: DIO_W]; // RULE23
    end
    if (!flt)
    begin
      sel1_d = plc_out1[2:0]; // RULE4
      sel2_d = two_eff ? plc_out3[2:0] : 3'h0; // RULE4
      wd1_d = plc_out0; // RULE6
      wd2_d = two_eff ? plc_out2 : 16'h0000; // RULE6
      if (ad_tick)
      begin
        // scale supplies signed counts or divisions already sized
        w0_d = slot1_weight; // RULE3 RULE24
        w2_d = two_eff ? slot2_weight : 16'h0000; // RULE3
      end
      if (!two_eff)
        w2_d = 16'h0000; // RULE1
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      dout_q <= '0;
      w0_q <= 16'h0000;
      w2_q <= 16'h0000;
      stat_q <= 16'h0000;
      sel1_q <= 3'h0;
      sel2_q <= 3'h0;
      wd1_q <= 16'h0000;
      wd2_q <= 16'h0000;
    end
    else if (ce)
    begin
      din_s1_q <= din_pin;
      din_s2_q <= din_s1_q;
      dout_q <= dout_d;
      w0_q <= w0_d;
      w2_q <= w2_d;
      stat_q <= stat_d;
      sel1_q <= sel1_d;
      sel2_q <= sel2_d;
      wd1_q <= wd1_d;
      wd2_q <= wd2_d;
    end
  end
  assign dout = dout_q;
  assign slot1_sel = sel1_q;
  assign slot2_sel = sel2_q;
  assign slot1_wdata = wd1_q;
  assign slot2_wdata = wd2_q;

  // ------------------------------------------------------------
  // float command handshake
  // ------------------------------------------------------------
  logic [15:0] prev_q, prev_d;
  spx_field_type ind_q, ind_d, fsel_q, fsel_d, lfield_q, lfield_d;
  logic [31:0] fval_q, fval_d, lval_q, lval_d;
  logic integ_q, integ_d, pend_q, pend_d, lstb_q, lstb_d;
  logic cmd_new, rot_app, rot_clr, rot_adv, fwr;
  logic [2:0] grp;
  spx_field_type code;

  function automatic logic [1:0] spx_next_ack(input logic [1:0] a);
    spx_next_ack = (a == 2'h3) ? 2'h1 : a + 2'h1;
  endfunction

  assign cmd_new = flt && (plc_out1 != prev_q); // RULE10
  assign grp = plc_out1[7:5];
  assign code = plc_out1[4:0];
  assign cur_sel = (mode_q == SPX_MODE_AUTO || mode_q == SPX_MODE_MAN) ? rot_cur : fsel_q;

  always_comb
  begin
    prev_d = plc_out1;
    ack_d = ack_q;
    ind_d = ind_q;
    mode_d = mode_q;
    fsel_d = fsel_q;
    fval_d = fval_q;
    integ_d = integ_q;
    pend_d = 1'b0;
    lstb_d = 1'b0;
    lfield_d = lfield_q;
    lval_d = lval_q;
    rot_app = bus_app;
    rot_clr = bus_clr;
    rot_adv = 1'b0;
    fwr = 1'b0;
    if (cmd_new)
    begin
      // controller holds off until this ack shows
      ack_d = spx_next_ack(ack_q); // RULE12 RULE13
      case (grp)
        `SPX_GRP_RT, `SPX_GRP_STATIC:
        begin
          mode_d = (grp == `SPX_GRP_RT) ? SPX_MODE_RT : SPX_MODE_STATIC;
          fsel_d = code;
          ind_d = code; // RULE12
          pend_d = 1'b1; // RULE15
        end
        `SPX_GRP_APPEND: rot_app = 1'b1; // RULE16
        `SPX_GRP_CLEAR: rot_clr = 1'b1;
        `SPX_GRP_LOAD:
        begin
          // operand words are already valid when the command word moves
          lstb_d = 1'b1; // RULE11
          lfield_d = code;
          lval_d = {plc_out2, plc_out3}; // RULE9 RULE20
        end
        default:
        begin
          if (code == `SPX_CMD_NEXT1 || code == `SPX_CMD_NEXT2)
          begin
            mode_d = SPX_MODE_MAN;
            rot_adv = (mode_q == SPX_MODE_MAN); // RULE18
            pend_d = 1'b1;
          end
          else if (code == `SPX_CMD_AUTO)
          begin
            mode_d = SPX_MODE_AUTO; // RULE17
            pend_d = 1'b1;
          end
        end
      endcase
    end
    else if (flt && (pend_q || (ad_tick && mode_q != SPX_MODE_STATIC)))
    begin
      fwr = 1'b1;
      fval_d = float_value; // RULE14 RULE20
      ind_d = cur_sel; // RULE12
      // both integrity bits flip in the same update as the data
      integ_d = !integ_q; // RULE21 RULE25
      rot_adv = ad_tick && !pend_q && mode_q == SPX_MODE_AUTO; // RULE17
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_q <= 16'h0000;
      ack_q <= `SPX_ACK_RST;
      ind_q <= `SPX_FIELD_GROSS;
      mode_q <= SPX_MODE_RT;
      fsel_q <= `SPX_FIELD_GROSS;
      fval_q <= 32'h0000_0000;
      integ_q <= 1'b0;
      pend_q <= 1'b0;
      lstb_q <= 1'b0;
      lfield_q <= `SPX_FIELD_GROSS;
      lval_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      prev_q <= prev_d;
      ack_q <= ack_d;
      ind_q <= ind_d;
      mode_q <= mode_d;
      fsel_q <= fsel_d;
      fval_q <= fval_d;
      integ_q <= integ_d;
      pend_q <= pend_d;
      lstb_q <= lstb_d;
      lfield_q <= lfield_d;
      lval_q <= lval_d;
    end
  end
  assign float_sel = cur_sel;
  assign load_stb = lstb_q;
  assign load_field = lfield_q;
  assign load_value = lval_q;

  spx_rotation #(
    .ROT_MAX(ROT_MAX)
  ) u_rot (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .ce(ce),
    .clr(rot_clr),
    .append(rot_app),
    .field_in(bus_app ? reg_wdata[4:0] : code),
    .advance(rot_adv),
    .cur_field(rot_cur),
    .count(rot_cnt),
    .ptr(rot_ptr)
  );

  // ------------------------------------------------------------
  // input image
  // ------------------------------------------------------------
  always_comb
  begin
    if (flt)
    begin
      plc_in0 = {integ_q, ack_q, ind_q, 8'h00}; // RULE7 RULE8 RULE21
      plc_in1 = fval_q[31:16]; // RULE8
      plc_in2 = fval_q[15:0]; // RULE8
      plc_in3 = {integ_q, stat_q[14:0]}; // RULE8 RULE21
    end
    else
    begin
      plc_in0 = w0_q; // RULE2 RULE5
      plc_in1 = stat_q; // RULE5
      plc_in2 = w2_q; // RULE5
      plc_in3 = two_eff ? stat_q : 16'h0000; // RULE1 RULE5
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_ack_on_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE12
    (ce && cmd_new) |=> (ack_q != $past(ack_q) && ack_q != 2'h0))
    else $error("new command not acknowledged");
  a_ack_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE10
    !(ce && cmd_new) |=> $stable(ack_q))
    else $error("ack moved without a new command");
  a_integ_data: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE25
    (ce && fwr) |=> (integ_q != $past(integ_q) && fval_q == $past(float_value)))
    else $error("integrity bits did not toggle with data");
  a_static_hold: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE15
    (mode_q == SPX_MODE_STATIC && !pend_q && !cmd_new) |=> $stable(fval_q))
    else $error("static value changed without command");
  a_rt_refresh: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE14
    (ce && flt && ad_tick && mode_q == SPX_MODE_RT && !cmd_new)
    |=> plc_in2 == $past(float_value[15:0]))
    else $error("real-time value not refreshed on tick");
  a_one_slot: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE1
    (!flt && !two_eff && $past(!two_eff) && $past(!flt)) |-> plc_in2 == 16'h0000)
    else $error("second slot active with one slot configured");
  a_weight_tick: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE3
    (ce && ad_tick && !flt && !fmt_d[1]) |=> plc_in0 == $past(slot1_weight))
    else $error("slot weight not taken on tick");
  a_dout_tick: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE23
    !(ce && ad_tick) |=> $stable(dout))
    else $error("discrete output moved off tick");
  a_load_once: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE11
    load_stb |-> (load_value == $past(lval_d) ##1 !load_stb))
    else $error("operand load not a single pulse");
endmodule // spx_exchange

// file: hw/spx_map.svh
// offsets, field positions, reset values and command codes of the slot exchange
// assumes inclusion by name from every file of the block
//
// Operation
// RULE1 - two slots integer/division, one slot float
// RULE2 - slot carries two input, two output words
// RULE3 - first input word of slot holds weight
// RULE4 - second output word bits 2:0 select quantity
// RULE5 - input words: weight, status, weight, status
// RULE6 - output words: data, command, data, command
// RULE7 - float format exchanges four words each way
// RULE8 - float input: response, float, float, status
// RULE9 - float output: reserved, command, float operand
// RULE10 - only a changed command word is new
// RULE11 - controller loads operand before changing command
// RULE12 - new command changes ack and indicator
// RULE13 - controller waits for ack before next command
// RULE14 - real-time value refreshed every update tick
// RULE15 - static value loaded once, held until command
// RULE16 - rotation list of up to nine entries
// RULE17 - automatic rotation advances each update tick
// RULE18 - alternating next-field codes step the rotation
// RULE19 - rotation retained; default is gross only; a reset clears the count here, so the list reads empty
// RULE20 - floats use 32-bit single-precision layout
// RULE21 - integrity bits in first and last byte
// RULE22 - controller reissues command after repeated mismatch; the controller model only raises retry
// RULE23 - discrete io moves only on update tick
// RULE24 - integer weight is signed sixteen-bit
// RULE25 - both integrity bits toggle with float data
`ifndef SPX_MAP_SVH
`define SPX_MAP_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define SPX_OFS_CTRL 8'h00
`define SPX_OFS_STATUS 8'h04
`define SPX_OFS_ROT 8'h08
// ------------------------------------------------------------
// field positions and reset values
// ------------------------------------------------------------
`define SPX_FMT_INT 2'h0
`define SPX_FMT_DIV 2'h1
`define SPX_FMT_FLT 2'h2
`define SPX_CTRL_TWO_BIT 2
`define SPX_ROT_CLR_BIT 5
`define SPX_RST_FMT 2'h0
`define SPX_RST_TWO 1'h0
`define SPX_ROT_MAX 9
`define SPX_FIELD_GROSS 5'h00
`define SPX_ACK_RST 2'h0
// ------------------------------------------------------------
// command word: bits 7:5 group, bits 4:0 field or code
// ------------------------------------------------------------
`define SPX_GRP_MISC 3'h0
`define SPX_GRP_RT 3'h1
`define SPX_GRP_STATIC 3'h2
`define SPX_GRP_APPEND 3'h3
`define SPX_GRP_CLEAR 3'h4
`define SPX_GRP_LOAD 3'h5
`define SPX_CMD_NEXT1 5'h01
`define SPX_CMD_NEXT2 5'h02
`define SPX_CMD_AUTO 5'h03
`endif

// file: hw/spx_pkg.sv
// types shared by the slot exchange modules
// assumes spx_map.svh for the numeric constants
package spx_pkg;
  // ------------------------------------------------------------
  // float report modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SPX_MODE_RT = 2'b00,
    SPX_MODE_STATIC = 2'b01,
    SPX_MODE_AUTO = 2'b10,
    SPX_MODE_MAN = 2'b11
  } spx_mode_type;
  typedef logic [4:0] spx_field_type;
endpackage

// file: hw/spx_rotation.sv
// rotation list of real-time field codes
// assumes single clock, firmware restores the list after power loss
`timescale 1ns/1ps
`include "spx_map.svh"
module spx_rotation
  import spx_pkg::*;
#(
  parameter int ROT_MAX = `SPX_ROT_MAX
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic append,
  input wire spx_field_type field_in,
  input wire logic advance,
  output spx_field_type cur_field,
  output logic [3:0] count,
  output logic [3:0] ptr
);
  spx_field_type ent_q [ROT_MAX];
  spx_field_type ent_d [ROT_MAX];
  logic [3:0] cnt_q, cnt_d, ptr_q, ptr_d;
  localparam logic [3:0] MAX4 = 4'(ROT_MAX);

  // ------------------------------------------------------------
  // list update
  // ------------------------------------------------------------
  always_comb
  begin
    ent_d = ent_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    if (clr)
    begin
      cnt_d = 4'h0;
      ptr_d = 4'h0;
    end
    else if (append && cnt_q < MAX4) // RULE16
    begin
      ent_d[cnt_q] = field_in;
      cnt_d = cnt_q + 4'h1;
    end
    else if (advance && cnt_q != 4'h0)
    begin
      ptr_d = (ptr_q + 4'h1 >= cnt_q) ? 4'h0 : ptr_q + 4'h1;
    end
  end

  // array holds no reset, but a warm reset clears count and pointer so the list reads empty
  always_ff @(posedge ref_clk)
  begin
    if (ce)
      ent_q <= ent_d;
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 4'h0;
      ptr_q <= 4'h0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
    end
  end

  // empty list reports gross weight only
  assign cur_field = (cnt_q == 4'h0) ? `SPX_FIELD_GROSS : ent_q[ptr_q]; // RULE19
  assign count = cnt_q;
  assign ptr = ptr_q;

  a_rot_bound: assert property (@(posedge ref_clk) disable iff (!rst_n)
    cnt_q <= MAX4 && (cnt_q == 4'h0 || ptr_q < cnt_q)) // RULE16
    else $error("rotation count or pointer out of range");
  a_rot_default: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ce && clr) |=> cur_field == `SPX_FIELD_GROSS) // RULE19
    else $error("cleared rotation does not report gross");
endmodule // spx_rotation

// file: bench/spx_plc_model.sv
// controller-side model: drives the output image, one command in flight
// assumes spx_exchange on the same ref_clk
`timescale 1ns/1ps
module spx_plc_model
  import spx_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic flt,
  input wire logic cmd_go,
  input wire logic [15:0] cmd_word,
  input wire logic [31:0] operand,
  input wire logic [15:0] img0,
  input wire logic [15:0] img1,
  input wire logic [15:0] img2,
  input wire logic [15:0] img3,
  input wire logic [15:0] plc_in0,
  input wire logic [15:0] plc_in3,
  output logic [15:0] plc_out0,
  output logic [15:0] plc_out1,
  output logic [15:0] plc_out2,
  output logic [15:0] plc_out3,
  output logic busy,
  output logic integ_ok,
  output logic retry
);
  // ------------
  // handshake
  // ------------
  logic [1:0] st_q;
  logic [1:0] ack_q;
  logic [1:0] bad_q;
  assign integ_ok = (plc_in0[15] == plc_in3[15]);
  // three torn reads in a row would call for a fresh command
  assign retry = (bad_q == 2'h3);
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= 2'h0;
      ack_q <= 2'h0;
      bad_q <= 2'h0;
      busy <= 1'b0;
      plc_out0 <= 16'h0000;
      plc_out1 <= 16'h0000;
      plc_out2 <= 16'h0000;
      plc_out3 <= 16'h0000;
    end
    else
    begin
      plc_out0 <= img0;
      if (!flt || integ_ok)
        bad_q <= 2'h0;
      else if (bad_q != 2'h3)
        bad_q <= bad_q + 2'h1;
      // command word held in float so a format switch is not a command
      if (!flt)
      begin
        plc_out1 <= img1;
        plc_out2 <= img2;
        plc_out3 <= img3;
      end
      case (st_q)
        2'h0:
          if (flt && cmd_go)
          begin
            {plc_out2, plc_out3} <= operand;
            busy <= 1'b1;
            st_q <= 2'h1;
          end
        2'h1:
        begin
          plc_out1 <= cmd_word;
          ack_q <= plc_in0[14:13];
          st_q <= 2'h2;
        end
        default:
          if (plc_in0[14:13] != ack_q)
          begin
            busy <= 1'b0;
            st_q <= 2'h0;
          end
      endcase
    end
  end
endmodule // spx_plc_model

// file: bench/spx_exchange_tb.sv
// self-checking bench for the slot exchange: image, handshake, rotation
// assumes spx_map.svh and spx_pkg compiled first, controller model alongside
`timescale 1ns/1ps
`include "spx_map.svh"
module spx_exchange_tb
  import spx_pkg::*;
;
  logic ref_clk, rst_n, reg_wr, reg_rd, ad_tick, flt, cmd_go, load_stb, busy, integ_ok;
  logic [7:0] reg_addr, nload;
  logic [31:0] reg_wdata, reg_rdata, operand, float_value, load_value, lval, lfsr, d;
  logic [15:0] po0, po1, po2, po3, pi0, pi1, pi2, pi3, img0, img1, img2, img3;
  logic [15:0] w1, w2, sts, cmd_word, s1wd, s2wd, live;
  logic [2:0] sel1, sel2;
  logic [3:0] din_pin, dout, dq;
  logic [1:0] ack_e;
  logic [4:0] s, lfld;
  spx_field_type float_sel, load_field;
  logic ce, retry;
  int fail_count, samples_checked, cyc, i, k;
  assign float_value = {live, 11'h000, float_sel};
  spx_exchange u_spx_exchange (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .plc_out0(po0), .plc_out1(po1), .plc_out2(po2), .plc_out3(po3),
    .plc_in0(pi0), .plc_in1(pi1), .plc_in2(pi2), .plc_in3(pi3), .ad_tick(ad_tick),
    .slot1_sel(sel1), .slot1_weight(w1), .slot2_sel(sel2), .slot2_weight(w2),
    .slot1_wdata(s1wd), .slot2_wdata(s2wd), .scale_status(sts), .float_sel(float_sel),
    .float_value(float_value), .load_stb(load_stb), .load_field(load_field),
    .load_value(load_value), .din_pin(din_pin), .dout(dout));
  spx_plc_model u_spx_plc_model (.ref_clk(ref_clk), .rst_n(rst_n), .flt(flt),
    .cmd_go(cmd_go), .cmd_word(cmd_word), .operand(operand), .img0(img0), .img1(img1),
    .img2(img2), .img3(img3), .plc_in0(pi0), .plc_in3(pi3), .plc_out0(po0),
    .plc_out1(po1), .plc_out2(po2), .plc_out3(po3), .busy(busy), .integ_ok(integ_ok),
    .retry(retry));
  // ------------
  // helpers
  // ------------
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // rotation holds fields 3..11 after the overfilled append run
  function automatic logic [4:0] nf(input logic [4:0] x);
    return (x == 5'h0b) ? 5'h03 : x + 5'h01;
  endfunction
  task automatic stop_test;
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    ad_tick <= 1'b1;
    @(posedge ref_clk);
    ad_tick <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic send(input logic [15:0] w, input logic [31:0] op);
    int n;
    @(posedge ref_clk);
    cmd_word <= w;
    operand <= op;
    cmd_go <= 1'b1;
    @(posedge ref_clk);
    cmd_go <= 1'b0;
    @(negedge ref_clk);
    for (n = 0; n < 40 && busy !== 1'b0; n++)
      @(negedge ref_clk);
    ack_e = (ack_e == 2'h3) ? 2'h1 : ack_e + 2'h1;
    cyc_wait(3);
    @(negedge ref_clk);
    chk(64'({busy, pi0[14:13]}), 64'({1'b0, ack_e}));
  endtask
  task automatic rep(input logic [2:0] g, input logic [4:0] f);
    logic pv;
    @(negedge ref_clk);
    pv = pi0[15];
    send({8'h00, g, f}, 32'h0);
    chk(64'(pi0[12:0]), 64'({f, 8'h00}));
    chk(64'({pi0[15], integ_ok}), 64'({~pv, 1'b1}));
    chk(64'({pi1, pi2}), 64'({live, 11'h000, f}));
  endtask
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (load_stb === 1'b1)
    begin
      nload <= nload + 8'h01;
      lfld <= load_field;
      lval <= load_value;
    end
    if (cyc == 20000)
    begin
      fail_count++;
      stop_test;
    end
  end
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ------------
  // sequence
  // ------------
  initial
  begin
    {rst_n, reg_wr, reg_rd, ad_tick, flt, cmd_go, reg_addr, reg_wdata, operand} = '0;
    {img0, img1, img2, img3, w1, w2, sts, cmd_word, live, din_pin, dq, ack_e} = '0;
    {nload, lfld, lval, fail_count, samples_checked, cyc} = '0;
    lfsr = 32'h3a1b97db;
    ce = 1'b1;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`SPX_OFS_CTRL, d);
    chk(64'(d), 64'h0);
    rd(8'hfc, d);
    chk(64'(d), 64'h0);
    rd(`SPX_OFS_ROT, d);
    chk(64'(d[4:0]), 64'(`SPX_FIELD_GROSS));
    for (i = 0; i < 8; i++)
    begin
      wr(`SPX_OFS_CTRL, i[0] ? 32'h5 : 32'h4);
      lfsr = nxt(lfsr);
      img0 <= lfsr[15:0];
      img1 <= lfsr[31:16];
      lfsr = nxt(lfsr);
      img2 <= lfsr[15:0];
      img3 <= lfsr[31:16];
      lfsr = nxt(lfsr);
      w1 <= (i == 0) ? 16'h8000 : lfsr[15:0];
      w2 <= lfsr[31:16];
      lfsr = nxt(lfsr);
      sts <= lfsr[15:0];
      din_pin <= lfsr[19:16];
      cyc_wait(4);
      @(negedge ref_clk);
      chk(64'({sel1, sel2, s1wd, s2wd}), 64'({img1[2:0], img3[2:0], img0, img2}));
      chk(64'(dout), 64'(dq));
      tick;
      chk({pi0, pi1, pi2, pi3}, {w1, sts[15:4], din_pin, w2, sts[15:4], din_pin});
      chk(64'(dout), 64'(img1[11:8]));
      dq = img1[11:8];
    end
    ce <= 1'b0;
    w1 <= ~w1;
    tick;
    chk(64'(pi0 ^ w1), 64'hffff);
    @(posedge ref_clk);
    ce <= 1'b1;
    wr(`SPX_OFS_CTRL, 32'h0);
    tick;
    chk(64'({pi2, pi3, sel2, s2wd}), 64'h0);
    wr(`SPX_OFS_CTRL, 32'h2);
    flt <= 1'b1;
    lfsr = nxt(lfsr);
    img0 <= lfsr[15:0];
    live <= lfsr[31:16];
    rep(`SPX_GRP_RT, 5'h01);
    @(posedge ref_clk);
    live <= ~live;
    tick;
    chk(64'({pi1, pi2, pi0[14:13]}), 64'({live, 11'h000, 5'h01, ack_e}));
    rep(`SPX_GRP_STATIC, 5'h07);
    @(posedge ref_clk);
    live <= ~live;
    tick;
    chk(64'({pi1, pi2, pi0[14:13]}), 64'({~live, 11'h000, 5'h07, ack_e}));
    lfsr = nxt(lfsr);
    send({8'h00, `SPX_GRP_LOAD, 5'h09}, lfsr);
    chk(64'({nload, lfld, lval}), 64'({8'h01, 5'h09, lfsr}));
    send({8'h00, `SPX_GRP_CLEAR, 5'h00}, 32'h0);
    rd(`SPX_OFS_STATUS, d);
    chk(64'(d[7:4]), 64'h0);
    for (k = 0; k < 10; k++)
      send({8'h00, `SPX_GRP_APPEND, 5'(k + 3)}, 32'h0);
    rd(`SPX_OFS_STATUS, d);
    chk(64'(d[7:4]), 64'(`SPX_ROT_MAX));
    send({8'h00, `SPX_GRP_MISC, `SPX_CMD_AUTO}, 32'h0);
    for (k = 0; k < 4; k++)
    begin
      s = float_sel;
      tick;
      chk(64'({float_sel, pi1, pi2}), 64'({nf(s), live, 11'h000, s}));
      chk(64'(retry), 64'h0);
    end
    send({8'h00, `SPX_GRP_MISC, `SPX_CMD_NEXT1}, 32'h0);
    for (k = 0; k < 4; k++)
    begin
      s = float_sel;
      send({8'h00, `SPX_GRP_MISC, k[0] ? `SPX_CMD_NEXT1 : `SPX_CMD_NEXT2}, 32'h0);
      chk(64'(float_sel), 64'(nf(s)));
    end
    wr(`SPX_OFS_ROT, 32'h20);
    rd(`SPX_OFS_STATUS, d);
    chk(64'(d[7:4]), 64'h0);
    wr(`SPX_OFS_ROT, 32'h04);
    rd(`SPX_OFS_ROT, d);
    chk(64'(d[4:0]), 64'h04);
    stop_test;
  end
endmodule // spx_exchange_tb
